/* File: core/isp_pkg.sv */
// Shared constants and types for the inductive sensor serial register port.
// Assumes both ends run on one 25 MHz system clock.
package isp_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Device register addresses
   localparam logic [6:0] ISP_A_REV      = 7'h00;
   localparam logic [6:0] ISP_A_CFG_LO   = 7'h01;
   localparam logic [6:0] ISP_A_LOCK_HI  = 7'h05;
   localparam logic [6:0] ISP_A_UTH_LO   = 7'h06;
   localparam logic [6:0] ISP_A_UTH_HI   = 7'h07;
   localparam logic [6:0] ISP_A_LTH_LO   = 7'h08;
   localparam logic [6:0] ISP_A_LTH_HI   = 7'h09;
   localparam logic [6:0] ISP_A_IRQ_CFG  = 7'h0A;
   localparam logic [6:0] ISP_A_PWR      = 7'h0B;
   localparam logic [6:0] ISP_A_STAT     = 7'h20;
   localparam logic [6:0] ISP_A_PROX_LO  = 7'h21;
   localparam logic [6:0] ISP_A_PROX_HI  = 7'h22;
   localparam logic [6:0] ISP_A_FREQ_LO  = 7'h23;
   localparam logic [6:0] ISP_A_FREQ_MID = 7'h24;
   localparam logic [6:0] ISP_A_FREQ_HI  = 7'h25;
   localparam logic [6:0] ISP_A_TB_CFG   = 7'h05;

   // Reset values of the writable registers 0x0B down to 0x01
   localparam logic [11:1][7:0] ISP_CFG_RST = {
      8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF,
      8'h01, 8'h1B, 8'h45, 8'h14, 8'h0E};

   ////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int ISP_RW_BIT      = 7;
   localparam int ISP_PWR_BIT     = 0;
   localparam int ISP_TBPD_BIT    = 0;
   localparam int ISP_ST_OSC_BIT  = 7;
   localparam int ISP_ST_DATA_READY_MODE_BIT = 6;
   localparam int ISP_ST_WAKE_BIT = 5;
   localparam int ISP_ST_CMP_BIT  = 4;

   // Interrupt pin function codes in bits 2:0 of the pin config register
   typedef enum logic [2:0] {
      ISP_IRQ_DATA_READY_MODE = 3'h0,
      ISP_IRQ_WAKE = 3'h1,
      ISP_IRQ_CMP  = 3'h2
   } isp_irq_e;

   ////////////////////////////////////////////////////////////////////////
   // Host command port map
   localparam logic [7:0] ISP_H_INSTR = 8'h00;
   localparam logic [7:0] ISP_H_CTRL  = 8'h01;
   localparam logic [7:0] ISP_H_STAT  = 8'h02;
   localparam logic [7:0] ISP_H_BUF   = 8'h08;
   localparam logic [3:0] ISP_H_MAXN  = 4'h8;

   // Serial clock timing: half period from the system clock period
   localparam int ISP_MCLK_NS      = 40;
   localparam int ISP_SCLK_HALF_NS = 320;
   localparam logic [3:0] ISP_HALF_CYC =
      4'(ISP_SCLK_HALF_NS / ISP_MCLK_NS);

   typedef enum logic [2:0] {
      ISP_H_IDLE  = 3'h0,
      ISP_H_LOW   = 3'h1,
      ISP_H_HIGH  = 3'h2,
      ISP_H_TAIL  = 3'h3
   } isp_hstate_e;

endpackage : isp_pkg

/* File: core/isp_spi_if.sv */
// Four-wire serial link plus interrupt line between host and sensor.
// Assumes the bench joins one device end and one host end through it.
interface isp_spi_if;
   logic sclk;
   logic chip_select_n;
   logic mosi;
   logic miso;
   logic miso_oe;
   logic interrupt_out_n;

   // Sensor end
   modport device (input sclk, input chip_select_n, input mosi,
                   output miso, output miso_oe, output interrupt_out_n);
   // Controller end
   modport host (output sclk, output chip_select_n, output mosi,
                 input miso, input interrupt_out_n);
endinterface : isp_spi_if

/* File: core/isp_device.sv */
// Sensor end: serial slave register file, result readout, interrupt pin.
// Assumes link pins are asynchronous to mclk and sclk is at least
// eight mclk periods long; results arrive with a one-cycle strobe.
//
// Contract
// - Comparator mode asserts above high, releases below low
// - Wake-up asserts above high, clears when mode off
// - Data-ready asserts on data, clears reading 0x21
// - New data during read pulses interrupt instead
// - Device is slave only, never starts transfers
// - Instruction byte: direction bit, 7-bit address, data
// - Direction 0 writes, direction 1 reads
// - Each chip select assertion restarts instruction decode
// - Launch on falling edge, capture on rising edge
// - Single write commits at 16th rising edge
// - Early chip select release discards the write
// - Held chip select auto-increments register address
// - Master holds select eight times one plus N
// - Extended read shifts next register every 8 clocks
// - Extended write stores next register every 8 clocks
// - Burst from 0x21 returns proximity then count
// - Active conversion makes 0x01 to 0x05 read-only
// - Software writes reserved bits with defaults only
// - Register 0x00 reads fixed silicon revision
module isp_device
   import isp_pkg::*;
#(
   parameter logic [7:0] REVISION_ID = 8'h5A  // Arbitrary value
)(
   input  wire logic        mclk,
   input  wire logic        reset_n,
   isp_spi_if.device        link,
   input  wire logic        new_data,
   input  wire logic [15:0] proximity,
   input  wire logic [23:0] freq_count,
   input  wire logic        osc_stalled,
   output logic             active_conversion,
   output logic             timebase_powerdown
);

   ////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic [2:0]       sclk_s;    // [0] first sync stage, [2] history
      logic [2:0]       cs_s;
      logic [1:0]       mosi_s;
      logic [2:0]       cnt;       // Bit within current byte
      logic             instr_done;
      logic             rd;
      logic [6:0]       addr;
      logic [7:0]       shin;
      logic [7:0]       shout;
      logic             miso;
      logic             miso_oe;
      logic             irq_n;
      logic [11:1][7:0] cfg;
      logic             data_ready_mode;
      logic             cmp;
      logic             wake;
      logic             osc;
      logic [15:0]      prox;
      logic [23:0]      freq;
   } isp_dev_s;

   isp_dev_s q, d;

   logic       sclk_rise;
   logic       sclk_fall;
   logic       cs_act;
   logic       cs_start;
   logic [7:0] byte_in;
   logic [7:0] status;
   logic [2:0] mode;
   logic       rd_busy;
   logic       pulse;
   logic [6:0] nxt_addr;
   logic [15:0] up_th;
   logic [15:0] lo_th;

   ////////////////////////////////////////////////////////////////////////
   // Read data selection for one register address
   function automatic logic [7:0] rd_byte(input isp_dev_s s,
                                          input logic [6:0] a,
                                          input logic [7:0] st);
      logic [7:0] r;
      r = 8'h00;
      if (a == ISP_A_REV) begin
         r = REVISION_ID;
      end else if (a >= ISP_A_CFG_LO && a <= ISP_A_PWR) begin
         r = s.cfg[a[3:0]];
      end else begin
         case (a)
            ISP_A_STAT:     r = st;
            ISP_A_PROX_LO:  r = s.prox[7:0];
            ISP_A_PROX_HI:  r = s.prox[15:8];
            ISP_A_FREQ_LO:  r = s.freq[7:0];
            ISP_A_FREQ_MID: r = s.freq[15:8];
            ISP_A_FREQ_HI:  r = s.freq[23:16];
            default:        r = 8'h00;
         endcase
      end
      return r;
   endfunction : rd_byte

   ////////////////////////////////////////////////////////////////////////
   // Edge detection on synchronised pins, status and thresholds
   assign sclk_rise = q.sclk_s[1] & ~q.sclk_s[2];
   assign sclk_fall = ~q.sclk_s[1] & q.sclk_s[2];
   assign cs_act    = ~q.cs_s[1];
   assign cs_start  = ~q.cs_s[1] & q.cs_s[2];
   assign byte_in   = {q.shin[6:0], q.mosi_s[1]};
   assign mode      = q.cfg[ISP_A_IRQ_CFG[3:0]][2:0];
   assign rd_busy   = cs_act & q.instr_done & q.rd;
   assign nxt_addr  = 7'(q.addr + 7'h01);
   assign up_th     = {q.cfg[ISP_A_UTH_HI[3:0]], q.cfg[ISP_A_UTH_LO[3:0]]};
   assign lo_th     = {q.cfg[ISP_A_LTH_HI[3:0]], q.cfg[ISP_A_LTH_LO[3:0]]};
   assign status    = {q.osc, ~q.data_ready_mode, q.wake, q.cmp, 4'h0};
   assign pulse     = new_data & rd_busy & (mode == ISP_IRQ_DATA_READY_MODE);

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      d = q;
      // Two-stage synchronisers, third stage only for edge history
      d.sclk_s = {q.sclk_s[1:0], link.sclk};
      d.cs_s   = {q.cs_s[1:0], link.chip_select_n};
      d.mosi_s = {q.mosi_s[0], link.mosi};
      d.osc    = osc_stalled;

      // Fresh access on every chip select assertion
      if (cs_start) begin
         d.cnt        = 3'h0;
         d.instr_done = 1'b0;
         d.rd         = 1'b0;
      end else if (cs_act && sclk_rise) begin
         d.shin = byte_in;
         d.cnt  = 3'(q.cnt + 3'h1);
         if (q.cnt == 3'h7) begin
            if (!q.instr_done) begin
               // Instruction byte complete
               d.instr_done = 1'b1;
               d.rd         = byte_in[ISP_RW_BIT];
               d.addr       = byte_in[6:0];
               d.shout      = rd_byte(q, byte_in[6:0], status);
            end else if (q.rd) begin
               // Next register for an extended read
               d.addr  = nxt_addr;
               d.shout = rd_byte(q, nxt_addr, status);
            end else begin
               // Data byte complete: commit, then advance
               if (q.addr >= ISP_A_CFG_LO && q.addr <= ISP_A_PWR &&
                   !(q.cfg[ISP_A_PWR[3:0]][ISP_PWR_BIT] &&
                     q.addr <= ISP_A_LOCK_HI)) begin
                  d.cfg[q.addr[3:0]] = byte_in;
               end
               d.addr = nxt_addr;
            end
         end
      end

      // Output bits launched on the falling edge, only while reading
      if (!cs_act) begin
         d.miso_oe = 1'b0;
         d.miso    = 1'b0;
      end else if (sclk_fall && q.instr_done && q.rd) begin
         d.miso_oe = 1'b1;
         d.miso    = q.shout[3'h7 - q.cnt];
      end

      // Result capture and data-ready flag
      if (new_data) begin
         d.prox = proximity;
         d.freq = freq_count;
         if (proximity > up_th) begin
            d.cmp = 1'b1;
         end else if (proximity < lo_th) begin
            d.cmp = 1'b0;
         end
      end
      // Reading 0x21 clears, but a fresh result wins over the clear
      if (cs_act && sclk_rise && q.cnt == 3'h7 && !q.instr_done &&
          byte_in[ISP_RW_BIT] && byte_in[6:0] == ISP_A_PROX_LO) begin
         d.data_ready_mode = 1'b0;
      end
      if (new_data && !pulse) begin
         d.data_ready_mode = 1'b1;
      end

      // Wake-up latch holds until the mode is switched away
      if (mode != ISP_IRQ_WAKE) begin
         d.wake = 1'b0;
      end else if (new_data && proximity > up_th) begin
         d.wake = 1'b1;
      end

      // Pin level per selected function
      case (mode)
         ISP_IRQ_DATA_READY_MODE: d.irq_n = ~(d.data_ready_mode | pulse);
         ISP_IRQ_WAKE: d.irq_n = ~d.wake;
         ISP_IRQ_CMP:  d.irq_n = ~d.cmp;
         default:      d.irq_n = 1'b1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         q            <= '0;
         q.sclk_s     <= 3'h0;
         q.cs_s       <= 3'h7;
         q.irq_n      <= 1'b1;
         q.cfg        <= ISP_CFG_RST;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs straight from state
   assign link.miso          = q.miso;
   assign link.miso_oe       = q.miso_oe;
   assign link.interrupt_out_n = q.irq_n;
   assign active_conversion  = q.cfg[ISP_A_PWR[3:0]][ISP_PWR_BIT];
   assign timebase_powerdown = q.cfg[ISP_A_TB_CFG[3:0]][ISP_TBPD_BIT];

endmodule : isp_device

/* File: core/isp_host.sv */
// Controller end: runs register transfers on the serial link for software.
// Assumes a software port on mclk; miso and interrupt are asynchronous.
module isp_host
   import isp_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       reset_n,
   isp_spi_if.host         link,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata
);

   ////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      isp_hstate_e     st;
      logic [3:0]      div;
      logic [6:0]      bitk;      // Bits clocked so far
      logic [6:0]      total;     // 8 x (1 + N)
      logic [7:0]      instr;
      logic [7:0][7:0] buff;      // Data out, replaced by data in
      logic [7:0]      rxsh;
      logic            sclk;
      logic            cs_n;
      logic            mosi;
      logic [1:0]      miso_s;
      logic [1:0]      irq_s;
      logic [7:0]      rdata;
   } isp_host_s;

   isp_host_s q, d;
   logic [6:0] k1;
   logic       busy;

   // Serial bit k of the stream: instruction first, then buffer bytes
   function automatic logic bit_at(input isp_host_s s, input logic [6:0] k);
      logic [2:0] b;
      b = 3'(k[6:3] - 4'h1);
      return (k[6:3] == 4'h0) ? s.instr[3'h7 - k[2:0]]
                              : s.buff[b][3'h7 - k[2:0]];
   endfunction : bit_at

   assign k1   = 7'(q.bitk + 7'h01);
   assign busy = (q.st != ISP_H_IDLE);

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      d        = q;
      d.miso_s = {q.miso_s[0], link.miso};
      d.irq_s  = {q.irq_s[0], link.interrupt_out_n};
      d.div    = 4'(q.div + 4'h1);

      // Software port
      if (rd) begin
         case (addr)
            ISP_H_INSTR: d.rdata = q.instr;
            ISP_H_STAT:  d.rdata = {6'h00, ~q.irq_s[1], busy};
            default: begin
               if (addr[7:3] == ISP_H_BUF[7:3]) begin
                  d.rdata = q.buff[addr[2:0]];
               end else begin
                  d.rdata = 8'h00;
               end
            end
         endcase
      end
      if (wr && !busy) begin
         if (addr == ISP_H_INSTR) begin
            d.instr = wdata;
         end else if (addr[7:3] == ISP_H_BUF[7:3]) begin
            d.buff[addr[2:0]] = wdata;
         end
      end

      case (q.st)
         ISP_H_IDLE: begin
            // Start with N data bytes, N from 1 to 8
            if (wr && addr == ISP_H_CTRL && wdata[3:0] != 4'h0 &&
                wdata[3:0] <= ISP_H_MAXN) begin
               d.cs_n  = 1'b0;
               d.total = {wdata[3:0] + 4'h1, 3'h0};
               d.bitk  = 7'h00;
               d.div   = 4'h0;
               d.mosi  = q.instr[ISP_RW_BIT];
               d.st    = ISP_H_LOW;
            end
         end
         ISP_H_LOW: begin
            if (q.div == ISP_HALF_CYC - 4'h1) begin
               d.div  = 4'h0;
               d.sclk = 1'b1;
               d.rxsh = {q.rxsh[6:0], q.miso_s[1]};
               if (q.bitk[6:3] != 4'h0 && q.bitk[2:0] == 3'h7) begin
                  d.buff[3'(q.bitk[6:3] - 4'h1)] =
                     {q.rxsh[6:0], q.miso_s[1]};
               end
               d.st = ISP_H_HIGH;
            end
         end
         ISP_H_HIGH: begin
            if (q.div == ISP_HALF_CYC - 4'h1) begin
               d.div  = 4'h0;
               d.sclk = 1'b0;
               d.bitk = k1;
               if (k1 == q.total) begin
                  d.st = ISP_H_TAIL;
               end else begin
                  d.mosi = bit_at(q, k1);
                  d.st   = ISP_H_LOW;
               end
            end
         end
         ISP_H_TAIL: begin
            // Select released only after the last clock
            if (q.div == ISP_HALF_CYC - 4'h1) begin
               d.cs_n = 1'b1;
               d.mosi = 1'b0;
               d.st   = ISP_H_IDLE;
            end
         end
         default: d.st = ISP_H_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         q       <= '0;
         q.st    <= ISP_H_IDLE;
         q.cs_n  <= 1'b1;
         q.irq_s <= 2'h3;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from state
   assign link.sclk          = q.sclk;
   assign link.chip_select_n = q.cs_n;
   assign link.mosi          = q.mosi;
   assign rdata              = q.rdata;

endmodule : isp_host

/* File: dv/isp_link_assertions.sv */
// Checker of the serial link between the host end and the sensor end.
// Assumes it sits beside the interface and samples it on mclk.
module isp_link_assertions
   import isp_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic sclk,
   input wire logic chip_select_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe,
   input wire logic interrupt_out_n
);
   timeunit 1ns;
   timeprecision 1ns;

   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);

   ////////////////////////////////////////////////////////////////////////
   // Rises in the frame and the instruction byte seen so far
   logic [7:0] rises_q;
   logic [7:0] instr_q;
   logic       rd_act;
   always_ff @(posedge mclk) begin
      if (!reset_n || chip_select_n) begin
         rises_q <= 8'h00;
         instr_q <= 8'h00;
      end else if ($rose(sclk)) begin
         rises_q <= rises_q + 8'h01;
         instr_q <= (rises_q < 8'h08) ? {instr_q[6:0], mosi} : instr_q;
      end
   end
   // Data phase of a read frame
   assign rd_act = !chip_select_n && rises_q >= 8'h08 && instr_q[7];

   ////////////////////////////////////////////////////////////////////////
   // Framing and edges of the link
   idle_clock_a: assert property (chip_select_n |-> !sclk)
      else $error("serial clock moves while deselected");
   frame_start_a: assert property ($fell(chip_select_n) |-> !sclk [*8])
      else $error("first clock rise too early after select");
   frame_end_a: assert property ($fell(sclk) |-> !chip_select_n [*8])
      else $error("select released too soon after a clock fall");
   half_period_a: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
      else $error("clock high phase not eight cycles");
   mosi_launch_a: assert property (
      !chip_select_n && $changed(mosi) |-> !sclk)
      else $error("host data changed while clock high");
   miso_launch_a: assert property (
      miso_oe && $past(miso_oe) && $changed(miso) |-> !sclk)
      else $error("sensor data changed while clock high");
   byte_frame_a: assert property ($rose(chip_select_n) |->
      rises_q[2:0] == 3'h0 && rises_q >= 8'h10)
      else $error("frame not whole bytes after instruction");
   idle_quiet_a: assert property (chip_select_n [*6] |-> !miso_oe)
      else $error("sensor drives data while deselected");

   ////////////////////////////////////////////////////////////////////////
   // Interrupt line against reads of the result
   irq_clear_a: assert property ($rose(sclk) && rises_q == 8'h07 &&
      {instr_q[6:0], mosi} == 8'hA1 |-> ##[1:8] interrupt_out_n)
      else $error("result read did not release interrupt");
   irq_pulse_a: assert property (
      rd_act && $fell(interrupt_out_n) |=> interrupt_out_n)
      else $error("interrupt held low during a read");

   // Main scenarios reached
   burst_c: cover property ($rose(chip_select_n) && rises_q == 8'h30);
   pulse_c: cover property (rd_act && $fell(interrupt_out_n));
   read_c: cover property (miso_oe && $rose(sclk));
endmodule : isp_link_assertions

/* File: dv/inductive_sensor_spi_regs_bench.sv */
// Bench for the serial register port: host end and sensor end joined.
// Assumes a 25 MHz mclk; a second sensor end is driven bit by bit.
module inductive_sensor_spi_regs_bench
   import isp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   typedef struct {
      logic [7:0]  ins;
      logic [3:0]  n;
      logic [63:0] tx;
      logic [63:0] rx;
   } isp_row_s;

   localparam logic [7:0] REV = 8'hC3;  // Arbitrary value
   logic        mclk = 1'b0;
   logic        reset_n = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [7:0]  wdata = 8'h00;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [7:0]  rdata;
   logic        new_data = 1'b0;
   logic [15:0] proximity = 16'h0000;
   logic [23:0] freq_count = 24'h00_0000;
   logic        osc_stalled = 1'b0;
   logic        act;
   logic        tbpd;
   logic [7:0]  got;
   int          lows;
   int          miscompares = 0;
   int          comparisons = 0;
   logic [16:0] cmp [3] = '{17'h0_0200, 17'h0_00C0, 17'h1_0040};
   isp_row_s    rows [9] = '{
      '{8'h80, 4'h1, 64'h0, 64'(REV)},
      '{8'h81, 4'h8, 64'h0, 64'h00FF_FF01_1B45_140E},
      '{8'h89, 4'h3, 64'h0, 64'h0},
      '{8'h06, 4'h4, 64'h7856_3412, 64'h0},
      '{8'h86, 4'h4, 64'h0, 64'h7856_3412},
      '{8'h00, 4'h1, 64'h33, 64'h0},
      '{8'h80, 4'h1, 64'h0, 64'(REV)},
      '{8'h05, 4'h1, 64'h0, 64'h0},
      '{8'h85, 4'h1, 64'h0, 64'h0}};
   isp_spi_if   link ();
   isp_spi_if   link_b ();

   ////////////////////////////////////////////////////////////////////////
   // Ends under test, a spare sensor end and the link checker
   isp_device #(.REVISION_ID(REV)) i_isp_device (
      .mclk(mclk), .reset_n(reset_n), .link(link), .new_data(new_data),
      .proximity(proximity), .freq_count(freq_count),
      .osc_stalled(osc_stalled), .active_conversion(act),
      .timebase_powerdown(tbpd));
   isp_device #(.REVISION_ID(REV)) i_isp_device_b (
      .mclk(mclk), .reset_n(reset_n), .link(link_b), .new_data(new_data),
      .proximity(proximity), .freq_count(freq_count),
      .osc_stalled(osc_stalled), .active_conversion(),
      .timebase_powerdown());
   isp_host i_isp_host (
      .mclk(mclk), .reset_n(reset_n), .link(link), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
   isp_link_assertions i_isp_link_assertions (
      .mclk(mclk), .reset_n(reset_n), .sclk(link.sclk),
      .chip_select_n(link.chip_select_n), .mosi(link.mosi),
      .miso(link.miso), .miso_oe(link.miso_oe),
      .interrupt_out_n(link.interrupt_out_n));

   // System clock
   always #20 mclk = ~mclk;

   ////////////////////////////////////////////////////////////////////////
   // Comparison, software port and transfer tasks
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic irq(input logic e);
      chk({7'h00, link.interrupt_out_n}, {7'h00, e});
   endtask : irq

   task automatic sw_wr(input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      @(posedge mclk);
   endtask : sw_wr

   task automatic sw_rd(input logic [7:0] a, output logic [7:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      @(posedge mclk);
      d = rdata;
   endtask : sw_rd

   // Start a transfer and poll busy under a bound
   task automatic xfer(input logic [7:0] ins, input logic [3:0] n);
      logic [7:0] s;
      sw_wr(ISP_H_INSTR, ins);
      sw_wr(ISP_H_CTRL, {4'h0, n});
      for (int i = 0; i < 800; i++) begin
         sw_rd(ISP_H_STAT, s);
         if (s[0] === 1'b0) break;
      end
      // A transfer still busy after the poll bound counts as a mismatch
      chk({7'h00, s[0]}, 8'h00);
   endtask : xfer

   task automatic put(input logic [7:0] ins, input logic [3:0] n,
                      input logic [63:0] tx);
      for (int i = 0; i < int'(n); i++) sw_wr(ISP_H_BUF + 8'(i), tx[8*i +: 8]);
      xfer(ins, n);
   endtask : put

   task automatic rd_buf(input logic [3:0] n, input logic [63:0] exp);
      for (int i = 0; i < int'(n); i++) begin
         sw_rd(ISP_H_BUF + 8'(i), got);
         chk(got, exp[8*i +: 8]);
      end
   endtask : rd_buf

   // One new result, then let the line settle
   task automatic feed(input logic [15:0] p);
      proximity <= p;
      new_data <= 1'b1;
      @(posedge mclk);
      new_data <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask : feed

   // Bit-level frame on the spare link, 320 ns clock, MSB first
   task automatic bb(input logic [15:0] tx, input int n,
                     output logic [7:0] rx);
      rx = 8'h00;
      link_b.chip_select_n <= 1'b0;
      for (int i = 0; i < n; i++) begin
         link_b.mosi <= tx[15-i];
         repeat (4) @(posedge mclk);
         link_b.sclk <= 1'b1;
         @(posedge mclk);
         rx = {rx[6:0], link_b.miso};
         repeat (3) @(posedge mclk);
         link_b.sclk <= 1'b0;
      end
      repeat (4) @(posedge mclk);
      link_b.chip_select_n <= 1'b1;
      link_b.mosi <= ~link_b.mosi;
      repeat (8) @(posedge mclk);
   endtask : bb

   task automatic complete_run;
      if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : complete_run

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      link_b.sclk = 1'b0;
      link_b.chip_select_n = 1'b1;
      link_b.mosi = 1'b0;
      repeat (8) @(posedge mclk);
      chk({3'h0, act, link.sclk, link.chip_select_n,
           link.interrupt_out_n, tbpd}, 8'h07);
      chk(rdata, 8'h00);
      reset_n <= 1'b1;
      repeat (3) @(posedge mclk);
      // Table of ordinary transfers
      foreach (rows[r]) begin
         put(rows[r].ins, rows[r].n, rows[r].tx);
         if (rows[r].ins[7]) rd_buf(rows[r].n, rows[r].rx);
      end
      // Active conversion locks the low configuration registers
      chk({7'h00, tbpd}, 8'h00);
      put(8'h0B, 4'h1, 64'h1);
      put(8'h05, 4'h1, 64'h1);
      chk({6'h00, act, tbpd}, 8'h02);
      put(8'h0B, 4'h1, 64'h0);
      sw_rd(ISP_H_INSTR, got);
      chk(got, 8'h0B);
      // Data ready, then one burst of both results
      freq_count <= 24'hAB_CDEF;
      feed(16'h1234);
      irq(1'b0);
      sw_rd(ISP_H_STAT, got);
      chk(got, 8'h02);
      xfer(8'hA1, 4'h5);
      rd_buf(4'h5, 64'hAB_CDEF_1234);
      irq(1'b1);
      // New result in the middle of a read gives a pulse only
      fork
         xfer(8'hA1, 4'h5);
         begin
            repeat (300) @(posedge mclk);
            proximity <= 16'h0042;
            new_data <= 1'b1;
            lows = 0;
            repeat (12) begin
               @(posedge mclk);
               new_data <= 1'b0;
               if (link.interrupt_out_n === 1'b0) lows++;
            end
            chk(8'(lows), 8'h01);
         end
      join
      irq(1'b1);
      // Wake-up holds the line until the mode is left
      put(8'h06, 4'h4, 64'h0080_0100);
      put(8'h0A, 4'h1, 64'h1);
      feed(16'h0200);
      irq(1'b0);
      feed(16'h0010);
      irq(1'b0);
      put(8'h0A, 4'h1, 64'h3);
      irq(1'b1);
      // Comparator with hysteresis
      put(8'h0A, 4'h1, 64'h2);
      foreach (cmp[k]) begin
         feed(cmp[k][15:0]);
         irq(cmp[k][16]);
      end
      // Status register: stalled oscillator, flag still pending, no wake
      osc_stalled <= 1'b1;
      xfer(8'hA0, 4'h1);
      rd_buf(4'h1, 64'h80);
      // Spare end: a short write is dropped, a whole one is kept
      bb(16'h03AA, 15, got);
      bb(16'h8300, 16, got);
      chk(got, 8'h45);
      bb(16'h03AA, 16, got);
      bb(16'h8300, 16, got);
      chk(got, 8'hAA);
      complete_run();
   end

   // Cut a hang short
   initial begin
      repeat (60000) @(posedge mclk);
      miscompares++;
      complete_run();
   end
endmodule : inductive_sensor_spi_regs_bench
